// >>> dv/serial_port_spi_clock_stop_tb.sv
`timescale 1ns/10ps
`include "spisc_defines.vh"
module serial_port_spi_clock_stop_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [1:0] mode;
    reg [7:0] div, tx_data, pword, w, col;
    reg pol, src, mst, tx_valid, s_clk, s_sel, s_mosi;
    wire tx_ready, rx_valid_r, cfg_ok_r, busy_r, sclk, sel_n, dout, dout_oe, miso;
    wire [7:0] rx_data_r, sent, got;
    integer seed = 46009, fails = 0, n_checks = 0, cycles = 0, i, b, k;
    integer qh = 0, qt = 0;
    reg [7:0] q [0:31];
    always #2.5 clk = ~clk;
    spisc_core DUT (.clk(clk), .rst(rst), .clock_stop_select(mode),
        .transmit_clock_polarity(1'b1), .rate_clock_source_select(src),
        .rate_clock_divider(div), .receive_frame_polarity(pol),
        .transmit_frame_polarity(pol), .transmit_clock_direction(mst),
        .transmit_frame_direction(mst), .receive_clock_direction(1'b0),
        .receive_frame_direction(1'b0), .cfg_ok_r(cfg_ok_r), .busy_r(busy_r),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .rx_valid_r(rx_valid_r), .rx_data_r(rx_data_r),
        .transmit_clock_pin_i(s_clk), .transmit_clock_pin_o(sclk),
        .transmit_clock_pin_oe(), .transmit_frame_pin_n_i(s_sel),
        .transmit_frame_pin_n_o(sel_n), .transmit_frame_pin_n_oe(),
        .receive_frame_pin_n_i(s_sel), .receive_data_pin(mst ? miso : s_mosi),
        .transmit_data_pin_o(dout), .transmit_data_pin_oe(dout_oe));
    spisc_peer u_peer (.sclk(sclk), .sel_n(sel_n), .mosi(dout), .miso(miso),
        .late(mode[0]), .pword(pword), .sent(sent), .got(got));
    task check(input [7:0] a, input [7:0] e);
    begin
        n_checks = n_checks + 1;
        if (a !== e)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h want %h", $time, a, e);
        end
    end
    endtask
    task push(input [7:0] v);
    begin
        @(negedge clk);
        tx_valid = 1'b1;
        tx_data = v;
        if (tx_ready === 1'b1)
        begin
            q[qt] = v;
            qt = qt + 1;
        end
        @(negedge clk);
        tx_valid = 1'b0;
    end
    endtask
    // bounded wait: 0 for a received word, 1 for select released
    task await(input integer which);
    begin
        for (k = 0; k < 3000 && !(which ? sel_n === 1'b1 : rx_valid_r === 1'b1);
                k = k + 1)
            @(posedge clk) #1;
        check(k == 3000, 0);
    end
    endtask
    task mframe;
    begin
        await(0);
        check(rx_data_r, sent);
        await(1);
        check(got, q[qh]);
        qh = qh + 1;
        pword = $random(seed);
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            fails = fails + 1;
            tally_and_finish;
        end
    end
    initial
    begin
        mode = `SPISC_STOP_NODELAY;
        {pol, src, mst, tx_valid, s_mosi} = 5'h0C;
        {s_clk, s_sel, div, tx_data} = {2'h3, 8'h01, 8'h00};
        pword = $random(seed);
        repeat (3) @(negedge clk);
        rst = 1'b0;
        // polarity 0 stalls the port while the buffer fills
        repeat (2) @(negedge clk);
        check(cfg_ok_r, 0);
        for (i = 0; i < 9; i = i + 1)
            push($random(seed));
        check(tx_ready, 0);
        check(busy_r, 0);
        pol = 1'b1;
        for (i = 0; i < 8; i = i + 1)
            mframe;
        for (i = 0; i < 12; i = i + 1)
        begin
            @(negedge clk);
            mode = i[0] ? `SPISC_STOP_DELAY : `SPISC_STOP_NODELAY;
            div = (i < 10) ? i >> 1 : $random(seed) & 8'h0F;
            push($random(seed));
            mframe;
        end
        @(negedge clk);
        mst = 1'b0;
        div = 8'h03;
        repeat (2) @(negedge clk);
        check(cfg_ok_r, 0);
        div = `SPISC_SLAVE_DIV;
        mode = `SPISC_STOP_DELAY;
        push($random(seed));
        check(cfg_ok_r, 1);
        w = $random(seed);
        s_sel = 1'b0;
        s_mosi = w[7];
        repeat (4) @(negedge clk);
        for (b = 7; b >= 0; b = b - 1)
        begin
            col = {col[6:0], dout};
            s_clk = 1'b0;
            repeat (4) @(negedge clk);
            s_clk = 1'b1;
            repeat (4) @(negedge clk);
            s_mosi = (b > 0) ? w[b-1] : 1'b0;
        end
        s_sel = 1'b1;
        repeat (3) @(negedge clk);
        check(dout_oe, 0);
        check(rx_data_r, w);
        check(col, q[qh]);
        tally_and_finish;
    end
endmodule

// >>> dv/spisc_monitor.sv
`timescale 1ns/10ps
`include "spisc_defines.vh"
module spisc_monitor (
    // clock and reset
    input wire clk,
    input wire rst,
    // configuration
    input wire [1:0] clock_stop_select,
    input wire [7:0] rate_clock_divider,
    input wire transmit_clock_direction,
    // status and pins
    input wire cfg_ok_r,
    input wire transmit_clock_pin_o,
    input wire transmit_clock_pin_oe,
    input wire transmit_frame_pin_n_o,
    input wire transmit_frame_pin_n_oe,
    input wire transmit_frame_pin_n_i,
    input wire transmit_data_pin_o,
    input wire transmit_data_pin_oe
);
    // ----------------------------------------
    // phase length tracking
    // ----------------------------------------
    reg prev_r;
    reg rose_r;
    reg [8:0] cnt_r;
    reg [8:0] low_r;
    wire [7:0] dv = rate_clock_divider;
    wire [8:0] t_len = (dv == 8'h00) ? 9'h002 : {1'b0, dv} + 9'h001;
    wire even = ~dv[0] & |dv;
    wire [8:0] l_len = even ? {2'b00, dv[7:1]} : t_len >> 1;
    wire [8:0] h_len = t_len - l_len;
    wire rise = transmit_clock_pin_o & ~prev_r;
    wire fall = ~transmit_clock_pin_o & prev_r;
    wire mst = transmit_clock_direction;
    wire m10 = mst && clock_stop_select == `SPISC_STOP_NODELAY;
    wire m11 = mst && clock_stop_select == `SPISC_STOP_DELAY;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev_r <= 1'b1;
            rose_r <= 1'b0;
            cnt_r <= 9'h000;
            low_r <= 9'h000;
        end
        else
        begin
            prev_r <= transmit_clock_pin_o;
            cnt_r <= (rise | fall) ? 9'h001 : cnt_r + 9'h001;
            if (rise)
                low_r <= cnt_r;
            rose_r <= transmit_frame_pin_n_o ? 1'b0 : (rise | rose_r);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_low; rise && mst |-> cnt_r == l_len; endproperty
    a_low: assert property (p_low) else $error("low phase length");
    property p_high; fall && rose_r && mst |-> cnt_r == h_len; endproperty
    a_high: assert property (p_high) else $error("high phase length");
    property p_period;
        fall && rose_r && mst |-> cnt_r + low_r == t_len;
    endproperty
    a_period: assert property (p_period) else $error("clock period");
    property p_idle;
        mst && transmit_clock_pin_oe && transmit_frame_pin_n_o
            |-> transmit_clock_pin_o;
    endproperty
    a_idle: assert property (p_idle) else $error("clock not idle");
    property p_sel;
        fall && mst |-> !transmit_frame_pin_n_o && !$past(transmit_frame_pin_n_o);
    endproperty
    a_sel: assert property (p_sel) else $error("select late");
    property p_l10;
        m10 && transmit_data_pin_oe && $past(transmit_data_pin_oe)
            && $changed(transmit_data_pin_o) |-> fall;
    endproperty
    a_l10: assert property (p_l10) else $error("launch off fall");
    property p_l11;
        m11 && transmit_data_pin_oe && $past(transmit_data_pin_oe)
            && $changed(transmit_data_pin_o) |-> rise;
    endproperty
    a_l11: assert property (p_l11) else $error("launch off rise");
    property p_oe;
        mst && $past(mst) && !$past(rst)
            |-> transmit_clock_pin_oe && transmit_frame_pin_n_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("master pins undriven");
    property p_rel;
        !mst && $rose(transmit_frame_pin_n_i) |-> ##[1:2] !transmit_data_pin_oe;
    endproperty
    a_rel: assert property (p_rel) else $error("data not released");
    property p_cfg;
        !$past(rst) && !$past(mst) && $past(rate_clock_divider) != 8'h01
            |-> !cfg_ok_r;
    endproperty
    a_cfg: assert property (p_cfg) else $error("bad slave rate taken");
    c_even: cover property (fall && rose_r && even);
    c_m11: cover property (rise && m11);
    c_rel: cover property (!mst && $rose(transmit_frame_pin_n_i));
endmodule

bind spisc_core spisc_monitor u_mon (.clk, .rst, .clock_stop_select,
    .rate_clock_divider, .transmit_clock_direction, .cfg_ok_r,
    .transmit_clock_pin_o, .transmit_clock_pin_oe, .transmit_frame_pin_n_o,
    .transmit_frame_pin_n_oe, .transmit_frame_pin_n_i, .transmit_data_pin_o,
    .transmit_data_pin_oe);

// >>> dv/spisc_peer.sv
`timescale 1ns/10ps
module spisc_peer (
    // serial lines
    input wire sclk,
    input wire sel_n,
    input wire mosi,
    output reg miso,
    // word control
    input wire late,
    input wire [7:0] pword,
    output reg [7:0] sent,
    output reg [7:0] got
);
    reg [7:0] sh = 8'h00;
    reg first = 1'b0;
    initial miso = 1'b0;
    initial sent = 8'h00;
    initial got = 8'h00;
    always @(negedge sel_n)
    begin
        sent = pword;
        miso = pword[7];
        sh = pword << 1;
        first = 1'b1;
    end
    // released line: never leave the old bit standing
    always @(posedge sel_n)
        miso = ~miso;
    always @(sclk)
    begin
        if (!sel_n && (sclk ^ late))
            got = {got[6:0], mosi};
        else if (!sel_n && !(first && !late))
        begin
            miso = sh[7];
            sh = sh << 1;
        end
        first = 1'b0;
    end
endmodule

// >>> logic/spisc_core.v
// Behaviour
// - slave mode needs rate clock at half cpu clock: source 1, divider 1
// - master serial clock period is (1 + divider) processor clock cycles, 2 when divider is 0
// - low phase half period for odd/zero divider, else divider/2 cycles
// - high phase half period for odd/zero divider, else divider/2+1
// - frame polarities 1; select is active low, inverted inside
// - master: tx clock/frame dir 1, rx dirs 0; slave: all four 0
// - master drops select before first clock edge, transfer follows
// - mode 10b: receive data sampled on rising serial clock
// - mode 10b: transmit bits launched from falling serial clock
// - mode 11b: receive data sampled on falling serial clock
// - mode 11b: transmit bits launched from rising serial clock
// - slave releases data output once select returns high
`timescale 1ns/10ps
`include "spisc_defines.vh"

// ----------------------------------------------------------------
// transmit word buffer
// ----------------------------------------------------------------
module spisc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // fill side
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output reg in_ready_r,
    // drain side
    output reg out_valid_r,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    reg [AW:0] count_nxt;
    wire push;
    wire pop;

    assign push = in_valid & in_ready_r;
    assign pop = out_ready & out_valid_r;
    assign out_data = mem_r[rd_ptr_r];

    always @*
    begin
        count_nxt = count_r;
        if (push & ~pop)
            count_nxt = count_r + 1'b1;
        else if (pop & ~push)
            count_nxt = count_r - 1'b1;
    end

    always @(posedge clk)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end

    // flags registered from the next count so both stay honest
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            in_ready_r <= 1'b1;
            out_valid_r <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}}
                                                    : wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}}
                                                    : rd_ptr_r + 1'b1;
            count_r <= count_nxt;
            in_ready_r <= (count_nxt != DEPTH);
            out_valid_r <= (count_nxt != {(AW+1){1'b0}});
        end
    end
endmodule

// ----------------------------------------------------------------
// clock-stop serial port, clock polarity high
// ----------------------------------------------------------------
module spisc_core #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // configuration
    input wire [1:0] clock_stop_select,
    input wire transmit_clock_polarity,
    input wire rate_clock_source_select,
    input wire [7:0] rate_clock_divider,
    input wire receive_frame_polarity,
    input wire transmit_frame_polarity,
    input wire transmit_clock_direction,
    input wire transmit_frame_direction,
    input wire receive_clock_direction,
    input wire receive_frame_direction,
    // status
    output reg cfg_ok_r,
    output reg busy_r,
    // transmit words in
    input wire tx_valid,
    input wire [WIDTH-1:0] tx_data,
    output wire tx_ready,
    // receive words out
    output reg rx_valid_r,
    output reg [WIDTH-1:0] rx_data_r,
    // serial clock pin
    input wire transmit_clock_pin_i,
    output reg transmit_clock_pin_o,
    output reg transmit_clock_pin_oe,
    // select pins, active low on the wire
    input wire transmit_frame_pin_n_i,
    output reg transmit_frame_pin_n_o,
    output reg transmit_frame_pin_n_oe,
    input wire receive_frame_pin_n_i,
    // data pins
    input wire receive_data_pin,
    output reg transmit_data_pin_o,
    output reg transmit_data_pin_oe
);
    localparam CW = $clog2(WIDTH) + 1;
    localparam EW = $clog2(2 * WIDTH) + 1;

    wire fifo_valid;
    wire [WIDTH-1:0] fifo_data;
    wire pop;

    reg [1:0] state_r;
    reg [8:0] cnt_r;
    reg [EW-1:0] edge_cnt_r;
    reg [CW-1:0] samp_cnt_r;
    reg [WIDTH-1:0] tx_sh_r;
    reg [WIDTH-1:0] rx_sh_r;
    reg sck_prev_r;
    reg sl_act_r;

    reg [7:0] div_eff;
    reg [8:0] per_len;
    reg [8:0] hi_len;
    reg [8:0] lo_len;
    reg cfg_nxt;
    reg is_master;
    reg mode_nodelay;
    reg fall;
    reg rise;
    reg samp_edge;
    reg launch_edge;

    spisc_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(tx_valid),
        .in_data(tx_data),
        .in_ready_r(tx_ready),
        .out_valid_r(fifo_valid),
        .out_data(fifo_data),
        .out_ready(pop)
    );

    // ------------------------------------------------------------
    // phase lengths and configuration check
    // ------------------------------------------------------------
    // a zero divider cannot give half a cycle; it runs as divider 1
    always @*
    begin
        div_eff = (rate_clock_divider == `SPISC_DIV_ZERO) ? `SPISC_DIV_MIN
                                                       : rate_clock_divider;
        per_len = {1'b0, div_eff} + 9'h001;
        if (div_eff[0])
            hi_len = per_len >> 1;
        else
            hi_len = {2'b00, div_eff[7:1]} + 9'h001;
        lo_len = per_len - hi_len;
        is_master = transmit_clock_direction;
        mode_nodelay = (clock_stop_select == `SPISC_STOP_NODELAY);
        cfg_nxt = clock_stop_select[1]
            & (transmit_clock_polarity == `SPISC_POL_REQ)
            & (receive_frame_polarity == `SPISC_POL_REQ)
            & (transmit_frame_polarity == `SPISC_POL_REQ)
            & ~receive_clock_direction & ~receive_frame_direction;
        if (is_master)
            cfg_nxt = cfg_nxt & transmit_frame_direction;
        else
            cfg_nxt = cfg_nxt & ~transmit_frame_direction
                & (rate_clock_source_select == `SPISC_SLAVE_SRC)
                & (rate_clock_divider == `SPISC_SLAVE_DIV);
    end

    // ------------------------------------------------------------
    // edge classification, shared by both roles
    // ------------------------------------------------------------
    always @*
    begin
        if (is_master)
        begin
            fall = (state_r == `SPISC_ST_RUN) & (cnt_r == 9'h000)
                & transmit_clock_pin_o;
            rise = (state_r == `SPISC_ST_RUN) & (cnt_r == 9'h000)
                & ~transmit_clock_pin_o;
        end
        else
        begin
            fall = sl_act_r & sck_prev_r & ~transmit_clock_pin_i;
            rise = sl_act_r & ~sck_prev_r & transmit_clock_pin_i;
        end
        samp_edge = mode_nodelay ? rise : fall;
        launch_edge = mode_nodelay ? fall : rise;
    end

    // master pops on start; slave pops when selected, if a word waits
    assign pop = fifo_valid & cfg_ok_r & (is_master
        ? (state_r == `SPISC_ST_IDLE)
        : (~transmit_frame_pin_n_i & ~sl_act_r));

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= `SPISC_ST_IDLE;
            cnt_r <= 9'h000;
            edge_cnt_r <= {EW{1'b0}};
            samp_cnt_r <= {CW{1'b0}};
            tx_sh_r <= {WIDTH{1'b0}};
            rx_sh_r <= {WIDTH{1'b0}};
            sck_prev_r <= `SPISC_CLK_IDLE;
            sl_act_r <= 1'b0;
            cfg_ok_r <= 1'b0;
            busy_r <= 1'b0;
            rx_valid_r <= 1'b0;
            rx_data_r <= {WIDTH{1'b0}};
            transmit_clock_pin_o <= `SPISC_CLK_IDLE;
            transmit_clock_pin_oe <= 1'b0;
            transmit_frame_pin_n_o <= `SPISC_SEL_IDLE;
            transmit_frame_pin_n_oe <= 1'b0;
            transmit_data_pin_o <= 1'b0;
            transmit_data_pin_oe <= 1'b0;
        end
        else
        begin
            cfg_ok_r <= cfg_nxt;
            rx_valid_r <= 1'b0;
            sck_prev_r <= transmit_clock_pin_i;
            transmit_clock_pin_oe <= is_master;
            transmit_frame_pin_n_oe <= is_master;
            if (samp_edge)
            begin
                rx_sh_r <= {rx_sh_r[WIDTH-2:0], receive_data_pin};
                samp_cnt_r <= samp_cnt_r + 1'b1;
                if (samp_cnt_r == WIDTH - 1)
                begin
                    rx_valid_r <= 1'b1;
                    rx_data_r <= {rx_sh_r[WIDTH-2:0], receive_data_pin};
                end
            end
            // first bit is already out when select drops
            if (launch_edge && samp_cnt_r != {CW{1'b0}})
            begin
                tx_sh_r <= {tx_sh_r[WIDTH-2:0], 1'b0};
                transmit_data_pin_o <= tx_sh_r[WIDTH-2];
            end
            if (is_master)
            begin
                sl_act_r <= 1'b0;
                case (state_r)
                `SPISC_ST_IDLE:
                begin
                    transmit_clock_pin_o <= `SPISC_CLK_IDLE;
                    transmit_frame_pin_n_o <= `SPISC_SEL_IDLE;
                    transmit_data_pin_oe <= 1'b0;
                    busy_r <= 1'b0;
                    if (pop)
                    begin
                        tx_sh_r <= fifo_data;
                        transmit_data_pin_o <= fifo_data[WIDTH-1];
                        transmit_data_pin_oe <= 1'b1;
                        transmit_frame_pin_n_o <= ~`SPISC_SEL_IDLE;
                        busy_r <= 1'b1;
                        samp_cnt_r <= {CW{1'b0}};
                        edge_cnt_r <= {EW{1'b0}};
                        // select leads first edge by D or T
                        cnt_r <= (mode_nodelay ? hi_len : per_len)
                            - 9'h001;
                        state_r <= `SPISC_ST_RUN;
                    end
                end
                `SPISC_ST_RUN:
                begin
                    if (cnt_r == 9'h000)
                    begin
                        transmit_clock_pin_o <= ~transmit_clock_pin_o;
                        edge_cnt_r <= edge_cnt_r + 1'b1;
                        if (edge_cnt_r == 2 * WIDTH - 1)
                        begin
                            cnt_r <= (mode_nodelay ? per_len : hi_len)
                                - 9'h001;
                            state_r <= `SPISC_ST_TAIL;
                        end
                        else if (transmit_clock_pin_o)
                            cnt_r <= lo_len - 9'h001;
                        else
                            cnt_r <= hi_len - 9'h001;
                    end
                    else
                        cnt_r <= cnt_r - 9'h001;
                end
                `SPISC_ST_TAIL:
                begin
                    if (cnt_r == 9'h000)
                    begin
                        transmit_frame_pin_n_o <= `SPISC_SEL_IDLE;
                        transmit_data_pin_oe <= 1'b0;
                        busy_r <= 1'b0;
                        state_r <= `SPISC_ST_IDLE;
                    end
                    else
                        cnt_r <= cnt_r - 9'h001;
                end
                default:
                    state_r <= `SPISC_ST_IDLE;
                endcase
            end
            else
            begin
                state_r <= `SPISC_ST_IDLE;
                transmit_clock_pin_o <= `SPISC_CLK_IDLE;
                transmit_frame_pin_n_o <= `SPISC_SEL_IDLE;
                // select sampled inverted: low on the wire means active
                if (transmit_frame_pin_n_i)
                begin
                    sl_act_r <= 1'b0;
                    transmit_data_pin_oe <= 1'b0;
                    busy_r <= 1'b0;
                end
                else if (~sl_act_r && cfg_ok_r)
                begin
                    sl_act_r <= 1'b1;
                    busy_r <= 1'b1;
                    samp_cnt_r <= {CW{1'b0}};
                    tx_sh_r <= pop ? fifo_data : {WIDTH{1'b0}};
                    transmit_data_pin_o <= pop & fifo_data[WIDTH-1];
                    transmit_data_pin_oe <= 1'b1;
                end
                // receive frame gates sampling in slave role
                if (receive_frame_pin_n_i)
                    samp_cnt_r <= {CW{1'b0}};
            end
        end
    end
endmodule

// >>> logic/spisc_defines.vh
`ifndef SPISC_DEFINES_VH
`define SPISC_DEFINES_VH

// ----------------------------------------------------------------
// clock-stop mode codes
// ----------------------------------------------------------------
`define SPISC_STOP_NODELAY 2'b10
`define SPISC_STOP_DELAY 2'b11

// ----------------------------------------------------------------
// required configuration values, idle levels and zero divider mapping
// ----------------------------------------------------------------
`define SPISC_SLAVE_DIV 8'h01
`define SPISC_SLAVE_SRC 1'b1
`define SPISC_POL_REQ 1'b1
`define SPISC_CLK_IDLE 1'b1
`define SPISC_SEL_IDLE 1'b1
`define SPISC_DIV_ZERO 8'h00
`define SPISC_DIV_MIN 8'h01

// ----------------------------------------------------------------
// master sequencer states
// ----------------------------------------------------------------
`define SPISC_ST_IDLE 2'h0
`define SPISC_ST_RUN 2'h1
`define SPISC_ST_TAIL 2'h2

`endif
